// ===== hw/ncoos_regs.svh
// Contract
// - output invert bit set inverts the oscillator output, clear passes it
// - polarity change with interrupts enabled raises an interrupt event; here only while module enabled and raw output unchanged that cycle
// - current output level is readable as a read-only status bit
// - polarity-adjusted output is routed to the waveform generator input
// - each accumulator carry sets the overflow interrupt flag
// - request only when module, overflow, peripheral and global enables set
// - reset clears every register, accumulator and increment to zero
// - module keeps running while processor sleeps if its clock runs
// - enabled with fast oscillator selected keeps that oscillator on in sleep
// - mode bit one selects pulse mode, zero selects fixed duty divide by two
// - enable at bit 7, writable invert bit, read-only status resets zero
// - fixed duty mode toggles output on every accumulator carry
// - pulse mode drives output active on the clock after a carry
// - pulse width in input clocks set by a three-bit width field
// - 20-bit accumulator adds increment each input clock; carry is event
`ifndef NCOOS_REGS_SVH
`define NCOOS_REGS_SVH
`define NCOOS_CTRL_OFS 12'h000
`define NCOOS_INC_OFS 12'h004
`define NCOOS_ACC_OFS 12'h008
`define NCOOS_CFG_OFS 12'h00c
`define NCOOS_IRQ_OFS 12'h010
`define NCOOS_EN_BIT 7
`define NCOOS_OUT_BIT 5
`define NCOOS_POL_BIT 4
`define NCOOS_PFM_BIT 0
`define NCOOS_PWS_HI 7
`define NCOOS_PWS_LO 5
`define NCOOS_CKS_HI 1
`define NCOOS_CKS_LO 0
`define NCOOS_IF_BIT 0
`define NCOOS_IE_BIT 1
`define NCOOS_PE_BIT 2
`define NCOOS_GE_BIT 3
`define NCOOS_FAST_OSC 2'b00
`define NCOOS_CTRL_WMASK 8'h91
`define NCOOS_ACC_W 20
`define NCOOS_RST8 8'h00
`define NCOOS_RST20 20'h00000
`endif

// ===== hw/ncoos_pkg.sv
package ncoos_pkg;
    typedef struct packed {
        logic en;
        logic pol;
        logic pfm;
    } ncoos_ctrl_s;

    typedef struct packed {
        ncoos_ctrl_s ctrl;
        logic [2:0] pws;
        logic [1:0] cks;
        logic [19:0] inc;
        logic [19:0] acc;
        logic raw;
        logic [7:0] pcnt;
        logic ovf_if;
        logic ovf_ie;
        logic pe_ie;
        logic g_ie;
        logic prev_out;
        logic [31:0] prdata;
    } ncoos_state_s;
endpackage

// ===== hw/ncoos_top.sv
`timescale 1ns/10ps
`include "ncoos_regs.svh"
module ncoos_top
    import ncoos_pkg::*;
#(
    parameter int ACC_W = `NCOOS_ACC_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // input clock enable of the selected oscillator source
    input wire logic nco_clk_en,
    // power
    input wire logic cpu_sleep,
    // outputs
    output logic wavegen_src,
    output logic overflow_irq_req,
    output logic fast_osc_keep_on,
    output logic [1:0] clk_source_sel
);
    ncoos_state_s st_ff;
    ncoos_state_s nxt_st;
    logic wr;
    logic rd;
    logic out_lvl;
    logic carry;
    logic [ACC_W:0] sum;
    logic [7:0] ctrl_rd;
    logic tick;
    logic ctrl_wr;
    logic acc_wr;
    logic cfg_wr;
    logic irq_wr;
    logic irq_en_all;
    logic pol_evt;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign sum = {1'b0, st_ff.acc} + {1'b0, st_ff.inc};
    assign carry = st_ff.ctrl.en && nco_clk_en && sum[ACC_W];
    // polarity applied last
    assign out_lvl = st_ff.raw ^ st_ff.ctrl.pol;
    assign ctrl_rd = {st_ff.ctrl.en, 1'b0, out_lvl, st_ff.ctrl.pol,
                      3'b000, st_ff.ctrl.pfm};

    assign tick = st_ff.ctrl.en && nco_clk_en;
    assign ctrl_wr = wr && paddr == `NCOOS_CTRL_OFS;
    assign acc_wr = wr && paddr == `NCOOS_ACC_OFS;
    assign cfg_wr = wr && paddr == `NCOOS_CFG_OFS;
    assign irq_wr = wr && paddr == `NCOOS_IRQ_OFS;
    assign irq_en_all = st_ff.ovf_ie && st_ff.pe_ie && st_ff.g_ie;

    always_comb begin
        nxt_st = st_ff;
        // accumulator runs only on its own clock enable, not the cpu clock
        if (st_ff.ctrl.en && nco_clk_en) begin
            nxt_st.acc = sum[ACC_W-1:0];
            if (st_ff.ctrl.pfm) begin
                if (carry) begin
                    nxt_st.raw = 1'b1;
                    nxt_st.pcnt = 8'h01 << st_ff.pws;
                end else if (st_ff.pcnt > 8'h01) begin
                    nxt_st.pcnt = st_ff.pcnt - 8'h01;
                end else begin
                    nxt_st.raw = 1'b0;
                    nxt_st.pcnt = 8'h00;
                end
            end else if (carry) begin
                nxt_st.raw = ~st_ff.raw;
            end
        end
        nxt_st.prev_out = out_lvl;
        if (wr) begin
            if (paddr == `NCOOS_CTRL_OFS) begin
                nxt_st.ctrl.en = pwdata[`NCOOS_EN_BIT];
                nxt_st.ctrl.pol = pwdata[`NCOOS_POL_BIT];
                nxt_st.ctrl.pfm = pwdata[`NCOOS_PFM_BIT];
            end else if (paddr == `NCOOS_INC_OFS) begin
                nxt_st.inc = pwdata[19:0];
            end else if (paddr == `NCOOS_ACC_OFS) begin
                nxt_st.acc = pwdata[19:0];
            end else if (paddr == `NCOOS_CFG_OFS) begin
                nxt_st.pws = pwdata[`NCOOS_PWS_HI:`NCOOS_PWS_LO];
                nxt_st.cks = pwdata[`NCOOS_CKS_HI:`NCOOS_CKS_LO];
            end else if (paddr == `NCOOS_IRQ_OFS) begin
                nxt_st.ovf_if = pwdata[`NCOOS_IF_BIT];
                nxt_st.ovf_ie = pwdata[`NCOOS_IE_BIT];
                nxt_st.pe_ie = pwdata[`NCOOS_PE_BIT];
                nxt_st.g_ie = pwdata[`NCOOS_GE_BIT];
            end
        end
        // set beats a same-cycle software clear
        if (carry) begin
            nxt_st.ovf_if = 1'b1;
        end
        // polarity flip while enabled makes an output edge worth flagging
        // no event when a raw toggle cancels the flip in the same cycle
        pol_evt = ctrl_wr && st_ff.ctrl.en && irq_en_all
                  && pwdata[`NCOOS_POL_BIT] != st_ff.ctrl.pol
                  && nxt_st.raw == st_ff.raw;
        if (pol_evt) begin
            nxt_st.ovf_if = 1'b1;
        end
        if (rd) begin
            if (paddr == `NCOOS_CTRL_OFS) begin
                nxt_st.prdata = {24'h000000, ctrl_rd};
            end else if (paddr == `NCOOS_INC_OFS) begin
                nxt_st.prdata = {12'h000, st_ff.inc};
            end else if (paddr == `NCOOS_ACC_OFS) begin
                nxt_st.prdata = {12'h000, st_ff.acc};
            end else if (paddr == `NCOOS_CFG_OFS) begin
                nxt_st.prdata = {24'h000000, st_ff.pws, 3'b000, st_ff.cks};
            end else if (paddr == `NCOOS_IRQ_OFS) begin
                nxt_st.prdata = {28'h0000000, st_ff.g_ie, st_ff.pe_ie,
                                 st_ff.ovf_ie, st_ff.ovf_if};
            end else begin
                nxt_st.prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wavegen_src = out_lvl;
    assign overflow_irq_req = st_ff.ovf_if && st_ff.ctrl.en && st_ff.ovf_ie
                              && st_ff.pe_ie && st_ff.g_ie;
    assign fast_osc_keep_on = st_ff.ctrl.en && cpu_sleep
                              && st_ff.cks == `NCOOS_FAST_OSC;
    assign clk_source_sel = st_ff.cks;

    // steps of a pulse in pulse mode
    sequence pf_carry_s;
        carry && st_ff.ctrl.pfm;
    endsequence

    sequence pf_one_s;
        carry && st_ff.ctrl.pfm && st_ff.pws == 3'd0;
    endsequence

    sequence pf_tick_s;
        tick && !carry && st_ff.ctrl.pfm;
    endsequence

    flag_set_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        carry |=> st_ff.ovf_if)
        else $error("carry lost");

    irq_gate_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        overflow_irq_req |-> st_ff.ctrl.en && st_ff.g_ie)
        else $error("irq ungated");

    no_autoclr_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st_ff.ovf_if && !wr |=> st_ff.ovf_if)
        else $error("flag self cleared");

    pol_out_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        wavegen_src == (st_ff.raw ^ st_ff.ctrl.pol))
        else $error("polarity wrong");

    fdc_tog_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        carry && !st_ff.ctrl.pfm |=> st_ff.raw != $past(st_ff.raw))
        else $error("no toggle");

    pf_rise_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        pf_carry_s |=> st_ff.raw)
        else $error("pulse missing");

    pf_one_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        pf_one_s ##1 pf_tick_s |=> !st_ff.raw)
        else $error("width wrong");

    unimpl_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ctrl_rd[6] == 1'b0 && ctrl_rd[3:1] == 3'b000)
        else $error("reserved set");

    acc_step_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        tick && !acc_wr |=> st_ff.acc == $past(sum[ACC_W-1:0]))
        else $error("accumulator step wrong");

    acc_hold_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !tick && !acc_wr |=> $stable(st_ff.acc))
        else $error("accumulator moved");

    sleep_run_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        tick && cpu_sleep && !acc_wr |=> st_ff.acc == $past(sum[ACC_W-1:0]))
        else $error("stopped in sleep");

    raw_idle_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !tick |=> $stable(st_ff.raw))
        else $error("output moved without tick");

    fdc_hold_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        tick && !carry && !st_ff.ctrl.pfm |=> $stable(st_ff.raw))
        else $error("toggle without carry");

    pf_load_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        pf_carry_s |=> st_ff.pcnt == 8'h01 << $past(st_ff.pws))
        else $error("width count wrong");

    pf_hold_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        pf_tick_s ##0 st_ff.pcnt > 8'h01 |=> $stable(st_ff.raw))
        else $error("pulse ended early");

    pf_end_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        pf_tick_s ##0 st_ff.pcnt <= 8'h01 |=> !st_ff.raw && st_ff.pcnt == 8'h00)
        else $error("pulse ended late");

    flag_clr_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        irq_wr && !pwdata[`NCOOS_IF_BIT] && !carry |=> !st_ff.ovf_if)
        else $error("flag not cleared");

    pol_evt_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        pol_evt |=> st_ff.ovf_if)
        else $error("polarity event lost");

    pol_edge_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st_ff.ctrl.en && irq_en_all && out_lvl != st_ff.prev_out
        && $stable(st_ff.raw) && $stable(st_ff.ctrl.en) |-> st_ff.ovf_if)
        else $error("polarity edge unflagged");

    req_if_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_ff.ovf_if |-> !overflow_irq_req)
        else $error("request without flag");

    req_en_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_ff.ctrl.en |-> !overflow_irq_req)
        else $error("request while disabled");

    req_ie_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_ff.ovf_ie |-> !overflow_irq_req)
        else $error("request without enable");

    req_pe_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_ff.pe_ie |-> !overflow_irq_req)
        else $error("request without peripheral enable");

    req_all_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st_ff.ovf_if && st_ff.ctrl.en && irq_en_all |-> overflow_irq_req)
        else $error("request missing");

    keep_wake_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !cpu_sleep |-> !fast_osc_keep_on)
        else $error("keep on while awake");

    keep_src_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st_ff.cks != `NCOOS_FAST_OSC |-> !fast_osc_keep_on)
        else $error("keep on for other source");

    keep_on_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        st_ff.ctrl.en && cpu_sleep && st_ff.cks == `NCOOS_FAST_OSC |-> fast_osc_keep_on)
        else $error("fast oscillator dropped");

    keep_off_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_ff.ctrl.en |-> !fast_osc_keep_on)
        else $error("keep on while disabled");

    status_bit_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ctrl_rd[`NCOOS_OUT_BIT] == wavegen_src)
        else $error("status bit wrong");

    status_rd_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        rd && paddr == `NCOOS_CTRL_OFS
        |=> prdata == {24'h000000, $past(ctrl_rd)})
        else $error("control read wrong");

    ctrl_wr_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ctrl_wr |=> st_ff.ctrl.en == $past(pwdata[`NCOOS_EN_BIT])
        && st_ff.ctrl.pol == $past(pwdata[`NCOOS_POL_BIT]))
        else $error("control write lost");

    mode_wr_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ctrl_wr |=> st_ff.ctrl.pfm == $past(pwdata[`NCOOS_PFM_BIT]))
        else $error("mode write lost");

    rst_clear_a: assert property (
        @(posedge core_clk)
        sys_rst |=> st_ff == '0)
        else $error("state not cleared");

    rst_out_a: assert property (
        @(posedge core_clk)
        sys_rst |=> !wavegen_src && !overflow_irq_req)
        else $error("outputs not cleared");

    width_wr_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        cfg_wr |=> st_ff.pws == $past(pwdata[`NCOOS_PWS_HI:`NCOOS_PWS_LO]))
        else $error("width write lost");

    src_wr_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        cfg_wr |=> clk_source_sel == $past(pwdata[`NCOOS_CKS_HI:`NCOOS_CKS_LO]))
        else $error("source write lost");

    carry_en_a: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !st_ff.ctrl.en |-> !carry)
        else $error("carry while disabled");
endmodule

// ===== tb/nco_output_stage_control_tb_top.sv
`timescale 1ns/10ps
`include "ncoos_regs.svh"
module nco_output_stage_control_tb_top;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, nco_clk_en = 0, cpu_sleep = 0;
    logic wavegen_src, overflow_irq_req, fast_osc_keep_on;
    logic [1:0] clk_source_sel;
    int error_cnt = 0, n_checks = 0;
    logic [31:0] exp_q[$];
    string name_q[$];
    ncoos_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nco_clk_en(nco_clk_en), .cpu_sleep(cpu_sleep),
        .wavegen_src(wavegen_src), .overflow_irq_req(overflow_irq_req),
        .fast_osc_keep_on(fast_osc_keep_on), .clk_source_sel(clk_source_sel));
    task check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one apb transfer; for reads d is the expected word
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input string nm);
        int k;
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        if (!wr) begin
            exp_q.push_back(d);
            name_q.push_back(nm);
        end
        @(posedge core_clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            give_verdict;
        end
        psel <= 0; penable <= 0;
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            nco_clk_en <= 1;
        end
        @(posedge core_clk);
        nco_clk_en <= 0;
    endtask
    task settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) check("read queue", 0, 1);
            else check(name_q.pop_front(), prdata, exp_q.pop_front());
        end
    initial forever #2 core_clk = ~core_clk;
    initial begin
        int n, i;
        logic [19:0] inc;
        logic [40:0] tot;
        void'($urandom(51379));
        repeat (8) @(posedge core_clk);
        sys_rst <= 0;
        for (i = 0; i < 6; i++)
            apb(0, i < 5 ? 12'(i * 4) : 12'h0fc, 0, "reset value");
        apb(1, `NCOOS_CTRL_OFS, 32'h4e, "");
        apb(0, `NCOOS_CTRL_OFS, 0, "unused bits");
        apb(1, `NCOOS_CTRL_OFS, 32'h10, "");
        settle;
        check("inverted output", wavegen_src, 1);
        apb(1, `NCOOS_CTRL_OFS, 0, "");
        cpu_sleep <= 1;
        inc = 20'($urandom);
        n = $urandom_range(40, 8);
        tot = n * inc;
        apb(1, `NCOOS_INC_OFS, {12'h000, inc}, "");
        apb(1, `NCOOS_CTRL_OFS, 32'h80, "");
        apb(0, `NCOOS_CTRL_OFS, 32'h80, "control readback");
        tick(n);
        settle;
        check("toggle output", wavegen_src, tot[20]);
        apb(0, `NCOOS_ACC_OFS, {12'h000, tot[19:0]}, "accumulator");
        apb(0, `NCOOS_IRQ_OFS, 32'(tot[40:20] != 0), "flag");
        apb(1, `NCOOS_INC_OFS, 32'h80000, "");
        tick(2);
        for (i = 0; i < 16; i++) begin
            apb(1, `NCOOS_CTRL_OFS, {24'h0, i[3], 7'h00}, "");
            apb(1, `NCOOS_IRQ_OFS, {28'h0, i[2:0], 1'b1}, "");
            settle;
            check("irq request", overflow_irq_req, i == 15);
        end
        repeat (50) @(posedge core_clk);
        apb(0, `NCOOS_IRQ_OFS, 32'hf, "flag held");
        apb(1, `NCOOS_IRQ_OFS, 32'he, "");
        apb(0, `NCOOS_IRQ_OFS, 32'he, "flag cleared");
        apb(1, `NCOOS_CTRL_OFS, 32'h90, "");
        apb(0, `NCOOS_IRQ_OFS, 32'hf, "polarity event");
        @(posedge core_clk);
        sys_rst <= 1;
        @(posedge core_clk);
        sys_rst <= 0;
        apb(0, `NCOOS_IRQ_OFS, 0, "flag after reset");
        apb(1, `NCOOS_CFG_OFS, 32'he0, "");
        apb(1, `NCOOS_INC_OFS, 32'h80000, "");
        apb(1, `NCOOS_CTRL_OFS, 32'h81, "");
        tick(5);
        settle;
        check("pulse output", wavegen_src, 1);
        check("keep fast osc", fast_osc_keep_on, 1);
        apb(0, `NCOOS_CTRL_OFS, 32'ha1, "status bit");
        apb(1, `NCOOS_CFG_OFS, 32'he1, "");
        apb(0, `NCOOS_CFG_OFS, 32'he1, "config readback");
        settle;
        check("source select", clk_source_sel, 1);
        check("release fast osc", fast_osc_keep_on, 0);
        give_verdict;
    end
endmodule
